/* src/sltr_cfg.svh */
// constants for the switch link tuning register group
// assumes a dword-aligned configuration port on the core clock
`ifndef SLTR_CFG_SVH
`define SLTR_CFG_SVH
`define SLTR_OFS_TEST1 8'h6c
`define SLTR_OFS_TIMER 8'h70
`define SLTR_OFS_MODE 8'h74
`define SLTR_RST_TEST1 32'h04000800
`define SLTR_RST_TIMER 32'h80000000
`define SLTR_RST_MODE 32'h00000002
`define SLTR_WMASK_TIMER 32'h7fff1fff
`define SLTR_LMASK_TIMER 32'hffff7fff
`define SLTR_MASK_MODE 32'h0000003f
`define SLTR_B_REPLAY_LO 0
`define SLTR_B_REPLAY_EN 12
`define SLTR_B_ACK_LO 16
`define SLTR_B_ACK_EN 30
`define SLTR_B_VGA 31
`define SLTR_B_STORE_FWD 0
`define SLTR_B_CUT_LO 1
`define SLTR_B_ARB_MODE 3
`define SLTR_B_CREDIT_MODE 4
`define SLTR_B_EGRESS_ORD 5
`define SLTR_NUM_FC_TYPES 3
`endif

/* src/sltr_pkg.sv */
// types for the switch link tuning register group
// assumes sltr_cfg.svh for all numeric constants
package sltr_pkg;
  typedef struct packed {
    logic req;
    logic wr;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } sltr_cfg_req_type;
  typedef struct packed {
    logic load;
    logic [7:0] addr;
    logic [31:0] data;
  } sltr_dflt_load_type;
endpackage : sltr_pkg

/* src/sltr_regs.sv */
// switch link tuning registers with the timer, forwarding, arbitration and credit logic
// assumes config requests and default loads come from logic on clk_sys_i
//
// Function
// - 12-bit user replay time-out, read-write, timer register low bits, resets zero.
// - replay override enable set selects user replay value; enable resets zero.
// - 14-bit user ack latency, read-write, timer upper half, resets zero.
// - ack override enable set selects user latency; enable resets zero.
// - read-only legacy video decode enable, resets one, enables decoding.
// - forwarding mode bit set is store-and-forward, clear (reset) cut-through.
// - slow-to-fast start at midpoint minus code cycles; field resets to 01b.
// - arbitration set holds pending port; clear moves to credited requesting port.
// - egress ordering mode set orders packets across different egress ports.
// - reset defaults replaceable by management bus or eeprom load.
// - 32-bit read-write test control word with fixed reset value.
`timescale 1ns/100ps
`default_nettype none
`include "sltr_cfg.svh"
module sltr_regs #(
  parameter int NPORT = 3,
  parameter int LW = 12
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire sltr_pkg::sltr_cfg_req_type cfg_i,
  input wire sltr_pkg::sltr_dflt_load_type dflt_i,
  output logic cfg_ack_o,
  output logic [31:0] cfg_rdata_o,
  input wire logic [11:0] replay_builtin_i,
  input wire logic [13:0] ack_default_i,
  output logic [11:0] replay_timeout_o,
  output logic [13:0] ack_latency_o,
  output logic vga_decode_o,
  output logic store_fwd_o,
  input wire logic [LW-1:0] pkt_len_i,
  output logic [LW-1:0] cut_start_o,
  input wire logic [NPORT-1:0] arb_req_i,
  input wire logic [NPORT-1:0] credit_ok_i,
  output logic arb_vld_o,
  output logic [$clog2(NPORT)-1:0] arb_port_o,
  input wire logic fc_update_i,
  output logic [`SLTR_NUM_FC_TYPES-1:0] fc_release_o,
  output logic egress_order_o
);
  import sltr_pkg::*;
  localparam int PW = $clog2(NPORT);

  if (NPORT < 2 || LW < 3) begin : g_chk
    $error("sltr_regs: NPORT must be at least 2 and LW at least 3");
  end

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  logic [31:0] test1;
  logic [31:0] timer;
  logic [31:0] mode;
  logic [31:0] bmask;
  logic wr_test1;
  logic wr_timer;
  logic wr_mode;

  assign bmask = {{8{cfg_i.be[3]}}, {8{cfg_i.be[2]}}, {8{cfg_i.be[1]}}, {8{cfg_i.be[0]}}};
  assign wr_test1 = cfg_i.req && cfg_i.wr && cfg_i.addr == `SLTR_OFS_TEST1;
  assign wr_timer = cfg_i.req && cfg_i.wr && cfg_i.addr == `SLTR_OFS_TIMER;
  assign wr_mode = cfg_i.req && cfg_i.wr && cfg_i.addr == `SLTR_OFS_MODE;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nv & m);
  endfunction : merge

  // default load takes priority over software so a late eeprom image still lands
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      test1 <= `SLTR_RST_TEST1;
    end else if (dflt_i.load && dflt_i.addr == `SLTR_OFS_TEST1) begin
      test1 <= dflt_i.data;
    end else if (wr_test1) begin
      test1 <= merge(test1, cfg_i.wdata, bmask);
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      timer <= `SLTR_RST_TIMER;
    end else if (dflt_i.load && dflt_i.addr == `SLTR_OFS_TIMER) begin
      timer <= dflt_i.data & `SLTR_LMASK_TIMER;
    end else if (wr_timer) begin
      // read-only bits such as video decode keep their loaded value
      timer <= merge(timer, cfg_i.wdata, bmask & `SLTR_WMASK_TIMER);
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      mode <= `SLTR_RST_MODE;
    end else if (dflt_i.load && dflt_i.addr == `SLTR_OFS_MODE) begin
      mode <= dflt_i.data & `SLTR_MASK_MODE;
    end else if (wr_mode) begin
      mode <= merge(mode, cfg_i.wdata, bmask & `SLTR_MASK_MODE);
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_ack_o <= 1'b0;
      cfg_rdata_o <= 32'h00000000;
    end else begin
      cfg_ack_o <= cfg_i.req;
      if (cfg_i.req && !cfg_i.wr) begin
        case (cfg_i.addr)
          `SLTR_OFS_TEST1: cfg_rdata_o <= test1;
          `SLTR_OFS_TIMER: cfg_rdata_o <= timer;
          `SLTR_OFS_MODE: cfg_rdata_o <= mode;
          default: cfg_rdata_o <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // timer and forwarding selection
  // ----------------------------------------
  logic [LW-1:0] half_len;
  logic [LW-1:0] cut_back;
  assign half_len = pkt_len_i >> 1;
  assign cut_back = LW'(mode[`SLTR_B_CUT_LO +: 2]);

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      replay_timeout_o <= 12'h000;
      ack_latency_o <= 14'h0000;
      vga_decode_o <= 1'b0;
      store_fwd_o <= 1'b0;
      cut_start_o <= '0;
      egress_order_o <= 1'b0;
    end else begin
      replay_timeout_o <= timer[`SLTR_B_REPLAY_EN] ? timer[`SLTR_B_REPLAY_LO +: 12]
                                                   : replay_builtin_i;
      ack_latency_o <= timer[`SLTR_B_ACK_EN] ? timer[`SLTR_B_ACK_LO +: 14]
                                             : ack_default_i;
      vga_decode_o <= timer[`SLTR_B_VGA];
      store_fwd_o <= mode[`SLTR_B_STORE_FWD];
      // saturate so a short packet never wraps to a late start
      cut_start_o <= (half_len > cut_back) ? half_len - cut_back : '0;
      egress_order_o <= mode[`SLTR_B_EGRESS_ORD];
    end
  end

  // ----------------------------------------
  // round-robin port arbitration
  // ----------------------------------------
  logic [NPORT-1:0] elig;
  logic [PW-1:0] next_port;
  logic next_found;
  logic hold;

  assign elig = mode[`SLTR_B_ARB_MODE] ? arb_req_i : (arb_req_i & credit_ok_i);
  assign hold = arb_vld_o && elig[arb_port_o];

  always_comb begin
    int idx;
    next_port = arb_port_o;
    next_found = 1'b0;
    idx = 0;
    for (int i = NPORT; i >= 1; i--) begin
      idx = (int'(arb_port_o) + i) % NPORT;
      if (elig[idx]) begin
        next_port = PW'(idx);
        next_found = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      arb_vld_o <= 1'b0;
      arb_port_o <= '0;
    end else if (hold) begin
      arb_vld_o <= 1'b1;
    end else begin
      arb_vld_o <= next_found;
      arb_port_o <= next_port;
    end
  end

  // ----------------------------------------
  // credit release pacing
  // ----------------------------------------
  logic [1:0] fc_type;
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      fc_type <= 2'h0;
      fc_release_o <= '0;
    end else if (!fc_update_i) begin
      fc_release_o <= '0;
    end else if (mode[`SLTR_B_CREDIT_MODE]) begin
      fc_release_o <= '1;
    end else begin
      fc_release_o <= `SLTR_NUM_FC_TYPES'(1) << fc_type;
      fc_type <= (fc_type == 2'(`SLTR_NUM_FC_TYPES - 1)) ? 2'h0 : fc_type + 2'h1;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_replay_user_sel: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    timer[`SLTR_B_REPLAY_EN] |=> replay_timeout_o == $past(timer[11:0]))
    else $error("replay time-out not user value");
  a_replay_builtin: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !timer[`SLTR_B_REPLAY_EN] |=> replay_timeout_o == $past(replay_builtin_i))
    else $error("replay time-out not built-in value");
  a_ack_user_sel: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    timer[`SLTR_B_ACK_EN] |=> ack_latency_o == $past(timer[29:16]))
    else $error("ack latency not user value");
  a_vga_read_only: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    wr_timer && !dflt_i.load |=> $stable(timer[`SLTR_B_VGA]))
    else $error("video decode bit changed by write");
  a_store_fwd_bit: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    wr_mode && !dflt_i.load && cfg_i.be[0] |=> ##1 store_fwd_o == $past(cfg_i.wdata[0], 2))
    else $error("forwarding mode not applied");
  a_cut_start_val: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !$past(reset_i) && $past(half_len) > 3 |-> cut_start_o == $past(half_len) - $past(cut_back))
    else $error("cut-through start wrong");
  a_arb_hold_port: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    arb_vld_o && mode[`SLTR_B_ARB_MODE] && arb_req_i[arb_port_o] |=> $stable(arb_port_o))
    else $error("arbiter left pending port");
  a_arb_credit_ok: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !mode[`SLTR_B_ARB_MODE] && !hold && next_found |=> arb_vld_o &&
      $past(credit_ok_i[next_port]))
    else $error("arbiter chose port without credit");
  a_credit_all_types: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    fc_update_i && mode[`SLTR_B_CREDIT_MODE] |=> fc_release_o == '1)
    else $error("credit not released for all types");
  a_credit_one_type: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    fc_update_i && !mode[`SLTR_B_CREDIT_MODE] |=> $onehot(fc_release_o))
    else $error("credit release not per type");
  a_test_word_rst: assert property (@(posedge clk_sys_i)
    $fell(reset_i) |-> test1 == `SLTR_RST_TEST1)
    else $error("test word reset value wrong");
endmodule : sltr_regs
`default_nettype wire

/* testbench/sltr_link_partner.sv */
// far-side link model: port queue requests, credit state, update strobes
// assumes the bench calls its tasks from one process on clk_sys_i
`timescale 1ns/100ps
`default_nettype none
module sltr_link_partner #(
  parameter int NPORT = 3
) (
  input wire logic clk_sys_i,
  output logic [NPORT-1:0] arb_req_o,
  output logic [NPORT-1:0] credit_ok_o,
  output logic fc_update_o
);
  initial begin
    arb_req_o = '0;
    credit_ok_o = '0;
    fc_update_o = 1'b0;
  end
  // queues change just after an edge, never on it
  task automatic queue(input logic [NPORT-1:0] r, input logic [NPORT-1:0] c);
    @(posedge clk_sys_i);
    #1;
    arb_req_o = r;
    credit_ok_o = c;
  endtask : queue
  // one-cycle credit update window
  task automatic update();
    @(posedge clk_sys_i);
    #1;
    fc_update_o = 1'b1;
    @(posedge clk_sys_i);
    #1;
    fc_update_o = 1'b0;
  endtask : update
endmodule : sltr_link_partner
`default_nettype wire

/* testbench/test_switch_link_tuning_regs.sv */
// self-checking bench for the switch link tuning registers
// assumes sltr_regs and the link partner model share one 100 MHz clock
`timescale 1ns/100ps
`default_nettype none
`include "sltr_cfg.svh"
module test_switch_link_tuning_regs;
  import sltr_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  sltr_cfg_req_type cfg_i = '0;
  sltr_dflt_load_type dflt_i = '0;
  logic [11:0] pkt_len_i = 12'h014;
  // driven, not tied, so a stale built-in value would show
  logic [11:0] replay_builtin_i = 12'h5a5;
  logic [13:0] ack_default_i = 14'h1234;
  logic cfg_ack_o, vga_decode_o, store_fwd_o, arb_vld_o, fc_update_i, egress_order_o;
  logic [31:0] cfg_rdata_o, q;
  logic [11:0] replay_timeout_o, cut_start_o;
  logic [13:0] ack_latency_o;
  logic [2:0] arb_req_i, credit_ok_i, fc_release_o;
  logic [1:0] arb_port_o;
  int n_errors = 0;
  int tests_run = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  sltr_regs #(.NPORT(3), .LW(12)) uut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .cfg_i(cfg_i), .dflt_i(dflt_i), .cfg_ack_o(cfg_ack_o), .cfg_rdata_o(cfg_rdata_o),
    .replay_builtin_i(replay_builtin_i), .ack_default_i(ack_default_i),
    .replay_timeout_o(replay_timeout_o),
    .ack_latency_o(ack_latency_o), .vga_decode_o(vga_decode_o), .store_fwd_o(store_fwd_o),
    .pkt_len_i(pkt_len_i), .cut_start_o(cut_start_o), .arb_req_i(arb_req_i),
    .credit_ok_i(credit_ok_i), .arb_vld_o(arb_vld_o), .arb_port_o(arb_port_o),
    .fc_update_i(fc_update_i), .fc_release_o(fc_release_o), .egress_order_o(egress_order_o));
  sltr_link_partner #(.NPORT(3)) lp (.clk_sys_i(clk_sys_i), .arb_req_o(arb_req_i),
    .credit_ok_o(credit_ok_i), .fc_update_o(fc_update_i));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : step
  // answer is fixed one cycle after the request edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    step(1);
    cfg_i = '{1'b1, w, a, 4'hf, d};
    step(1);
    cfg_i.req = 1'b0;
    chk("cfg_ack", 1, cfg_ack_o);
    q = cfg_rdata_o;
  endtask : acc
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    acc(1'b0, a, 32'h0);
    chk(n, e, q);
  endtask : rd
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd(`SLTR_OFS_TEST1, 32'h04000800, "test_word");
    rd(`SLTR_OFS_TIMER, 32'h80000000, "timer_reg");
    rd(`SLTR_OFS_MODE, 32'h00000002, "mode_reg");
    chk("replay", 12'h5a5, replay_timeout_o);
    chk("ack_lat", 14'h1234, ack_latency_o);
    chk("vga", 1, vga_decode_o);
    chk("cut_start", 9, cut_start_o);
    chk("store_fwd", 0, store_fwd_o);
    acc(1'b1, `SLTR_OFS_TEST1, 32'h5a5a0ff0);
    rd(`SLTR_OFS_TEST1, 32'h5a5a0ff0, "test_word_rw");
    $display("reset test done");
  endtask : t_reset
  task automatic t_timer;
    acc(1'b1, `SLTR_OFS_TIMER, 32'hffffffff);
    rd(`SLTR_OFS_TIMER, 32'hffff1fff, "timer_rw");
    chk("replay_user", 12'hfff, replay_timeout_o);
    chk("ack_user", 14'h3fff, ack_latency_o);
    acc(1'b1, `SLTR_OFS_TIMER, 32'h01230123);
    step(1);
    chk("replay_off", 12'h5a5, replay_timeout_o);
    chk("ack_off", 14'h1234, ack_latency_o);
    chk("vga_ro", 1, vga_decode_o);
    rd(`SLTR_OFS_TIMER, 32'h81230123, "timer_ro");
    replay_builtin_i = 12'h3c3;
    ack_default_i = 14'h0f0f;
    step(2);
    chk("replay_track", 12'h3c3, replay_timeout_o);
    chk("ack_track", 14'h0f0f, ack_latency_o);
    $display("timer test done");
  endtask : t_timer
  task automatic t_mode;
    for (int c = 0; c < 4; c++) begin
      acc(1'b1, `SLTR_OFS_MODE, 32'(c * 2 + 1));
      step(1);
      chk("cut_start", 32'(10 - c), cut_start_o);
      chk("store_fwd", 1, store_fwd_o);
    end
    pkt_len_i = 12'h004;
    step(2);
    chk("cut_floor", 0, cut_start_o);
    pkt_len_i = 12'h014;
    acc(1'b1, `SLTR_OFS_MODE, 32'hffffffff);
    rd(`SLTR_OFS_MODE, 32'h0000003f, "mode_rw");
    chk("egress", 1, egress_order_o);
    acc(1'b1, 8'h7c, 32'hffffffff);
    rd(8'h7c, 32'h0, "unmapped");
    $display("mode test done");
  endtask : t_mode
  task automatic t_arb;
    acc(1'b1, `SLTR_OFS_MODE, 32'h0);
    lp.queue(3'b011, 3'b010);
    step(2);
    chk("arb_vld", 1, arb_vld_o);
    chk("arb_port", 1, arb_port_o);
    lp.queue(3'b011, 3'b000);
    step(2);
    chk("arb_none", 0, arb_vld_o);
    acc(1'b1, `SLTR_OFS_MODE, 32'h8);
    lp.queue(3'b001, 3'b000);
    step(2);
    chk("arb_stay_vld", 1, arb_vld_o);
    lp.queue(3'b101, 3'b000);
    step(2);
    chk("arb_stay_port", 0, arb_port_o);
    $display("arbitration test done");
  endtask : t_arb
  task automatic t_credit;
    acc(1'b1, `SLTR_OFS_MODE, 32'h0);
    for (int i = 0; i < 3; i++) begin
      lp.update();
      chk("fc_type", 32'(3'b001 << i), fc_release_o);
    end
    step(1);
    chk("fc_idle", 0, fc_release_o);
    acc(1'b1, `SLTR_OFS_MODE, 32'h10);
    lp.update();
    chk("fc_all", 3'b111, fc_release_o);
    $display("credit test done");
  endtask : t_credit
  // default load and software write at the same edge: load must win
  task automatic t_dflt;
    step(1);
    dflt_i = '{1'b1, `SLTR_OFS_TIMER, 32'h0};
    cfg_i = '{1'b1, 1'b1, `SLTR_OFS_TIMER, 4'hf, 32'h00001234};
    step(1);
    dflt_i.load = 1'b0;
    cfg_i.req = 1'b0;
    rd(`SLTR_OFS_TIMER, 32'h0, "timer_dflt");
    chk("vga_dflt", 0, vga_decode_o);
    step(1);
    dflt_i = '{1'b1, `SLTR_OFS_MODE, 32'h21};
    step(2);
    dflt_i.load = 1'b0;
    chk("store_dflt", 1, store_fwd_o);
    chk("egress_dflt", 1, egress_order_o);
    $display("default load test done");
  endtask : t_dflt
  // reset in mid-run must drop loaded and written values
  task automatic t_rerst;
    step(1);
    reset_i = 1'b1;
    step(2);
    reset_i = 1'b0;
    rd(`SLTR_OFS_TIMER, 32'h80000000, "timer_rerst");
    rd(`SLTR_OFS_TEST1, 32'h04000800, "test_word_rerst");
    rd(`SLTR_OFS_MODE, 32'h00000002, "mode_rerst");
    chk("vga_rerst", 1, vga_decode_o);
    chk("cut_rerst", 9, cut_start_o);
    chk("store_rerst", 0, store_fwd_o);
    chk("egress_rerst", 0, egress_order_o);
    $display("mid-run reset test done");
  endtask : t_rerst
  initial begin
    step(4);
    reset_i = 1'b0;
    step(1);
    t_reset();
    t_timer();
    t_mode();
    t_arb();
    t_credit();
    t_dflt();
    t_rerst();
    end_of_test();
  end
  initial begin
    #200000;
    n_errors++;
    $display("[ERR] run_time expected end seen timeout");
    end_of_test();
  end
endmodule : test_switch_link_tuning_regs
`default_nettype wire
